// ==== utrd_map.svh ====
`ifndef UTRD_MAP_SVH
`define UTRD_MAP_SVH
// Notes on behaviour
// - Buffer-empty flag is high while the transmit buffer holds no unsent character.
// - Buffer-empty interrupt request stays high while enabled, flag set and globally enabled.
// - Writing the transmit data location clears the buffer-empty flag.
// - Transmit-complete flag sets when a frame ends and no character waits.
// - Transmit-complete flag clears on interrupt service or on writing one to it.
// - Transmit-complete interrupt is requested once the flag sets, when enabled.
// - With parity enabled, a parity bit follows the last data bit.
// - Clearing transmitter enable acts only after shift register and buffer are empty.
// - Once truly disabled, the transmitter releases the serial output pin.
// - Receiver enable starts reception and takes over the serial input pin.
// - Synchronous mode times received bits from the external transfer clock.
// - Reception starts on a valid start bit, then shifts bits to first stop.
// - A second stop bit is ignored by the receiver.
// - At the first stop bit the frame moves into the receive buffer.
// - Unused upper data bits of short characters read as zero.
// - Reading received data advances the FIFO; ninth bit and error flags follow.
// - The ninth bit may mark an address frame in multi-processor mode.
// - Frame is low start, data LSB first, optional parity, high stops.
// - Parity is xor of data bits, inverted for odd parity.
// - Shift register loads the buffer when idle or right after the last stop.
`define UTRD_OFF_DATA 12'h000
`define UTRD_OFF_STATUS 12'h004
`define UTRD_OFF_CTRL 12'h008
`define UTRD_OFF_CFG 12'h00c
`define UTRD_OFF_BAUD 12'h010
`define UTRD_ST_RXC 7
`define UTRD_ST_TXC 6
`define UTRD_ST_BE 5
`define UTRD_ST_FE 4
`define UTRD_ST_DOR 3
`define UTRD_ST_PE 2
`define UTRD_CT_TXCIE 6
`define UTRD_CT_BEIE 5
`define UTRD_CT_RXEN 4
`define UTRD_CT_TRANSMITTER_ENABLE 3
`define UTRD_CT_CS2 2
`define UTRD_CT_RX9 1
`define UTRD_CT_TX9 0
`define UTRD_CF_CS_HI 1
`define UTRD_CF_CS_LO 0
`define UTRD_CF_STOP2 3
`define UTRD_CF_PAR_HI 5
`define UTRD_CF_PAR_LO 4
`define UTRD_CF_SYNC 6
`define UTRD_CS_NINE 3'h7
`define UTRD_CS_RESET 3'h3
`define UTRD_NBITS_MIN 4'h5
`define UTRD_NBITS_EIGHT 4'h8
`define UTRD_NBITS_NINE 4'h9
`define UTRD_OS_MID 4'h7
`define UTRD_OS_LAST 4'hf
`define UTRD_BAUD_RESET 16'h0040
`define UTRD_FIFO_DEPTH 2'h2
`define UTRD_SYNC_RESET 2'h1
`endif

// ==== utrd_pkg.sv ====
package utrd_pkg;
	typedef enum logic [2:0] {
		UTRD_IDLE = 3'h0,
		UTRD_START = 3'h1,
		UTRD_DATA = 3'h3,
		UTRD_PAR = 3'h2,
		UTRD_STOP = 3'h6
	} utrd_state_t;
	typedef struct packed {
		logic ninth;
		logic [7:0] data;
		logic fe;
		logic dor;
		logic pe;
	} utrd_rx_entry_t;
	typedef struct packed {
		logic sync_mode;
		logic [1:0] parity_mode;
		logic two_stop;
		logic [2:0] char_size;
	} utrd_frame_cfg_t;
endpackage : utrd_pkg

// ==== utrd_sync.sv ====
`timescale 1ns/100ps
module utrd_sync
#(
	parameter int WIDTH = 2,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1_r;
	// Two flip-flops per bit; only the second stage is read outside.
	for (genvar i = 0; i < WIDTH; i++)
	begin : g_bit
		always_ff @(posedge ref_clk)
		begin
			if (rst)
			begin
				stage1_r[i] <= RESET_VAL[i];
				sync_out[i] <= RESET_VAL[i];
			end
			else
			begin
				stage1_r[i] <= async_in[i];
				sync_out[i] <= stage1_r[i];
			end
		end
	end
endmodule : utrd_sync

// ==== utrd_baud.sv ====
`timescale 1ns/100ps
module utrd_baud
#(
	parameter int DIV_W = 16
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [DIV_W-1:0] divisor,
	output logic tick
);
	logic [DIV_W-1:0] cnt_r;
	// One tick every divisor plus one clocks, sixteen ticks to a bit.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			cnt_r <= '0;
			tick <= 1'b0;
		end
		else if (cnt_r >= divisor)
		begin
			cnt_r <= '0;
			tick <= 1'b1;
		end
		else
		begin
			cnt_r <= cnt_r + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule : utrd_baud

// ==== utrd_top.sv ====
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/100ps
`include "utrd_map.svh"
module utrd_top
	import utrd_pkg::*;
#(
	parameter int DIV_W = 16
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic global_irq_enable,
	input wire logic tx_complete_irq_ack,
	output logic irq_buffer_empty,
	output logic irq_tx_complete,
	output logic serial_out_pin,
	output logic serial_out_oe,
	input wire logic serial_in_pin,
	output logic serial_in_override,
	input wire logic sync_transfer_clock_pin
);
	logic tx_buffer_empty_irq_enable, tx_complete_irq_enable, receiver_enable, transmitter_enable, tx_ninth_bit;
	utrd_frame_cfg_t cfg_r;
	logic [DIV_W-1:0] baud_div_r;
	logic [31:0] prdata_r;
	logic pready_r, pslverr_r, irq_be_r, irq_tc_r;
	logic [8:0] tx_buf_r, tx_shreg_r;
	logic tx_buf_full_r, tx_complete_flag, tx_active_r, tx_stop2_r, serial_out_r;
	logic [3:0] tx_bit_r, tx_os_r;
	utrd_state_t tx_state_r, rx_state_r;
	logic [8:0] rx_shreg_r;
	logic [3:0] rx_bit_r, rx_os_r;
	logic rx_par_r, rx_hold_v_r, dor_pend_r, xck_prev_r;
	utrd_rx_entry_t rx_hold_r;
	utrd_rx_entry_t rx_fifo_r [`UTRD_FIFO_DEPTH];
	logic rx_rd_r, rx_wr_r;
	logic [1:0] rx_count_r;
	logic [1:0] pins_s;
	logic os_tick, xck_s, rxd_s, xck_rise, xck_fall;
	logic apb_setup, apb_wr, apb_rd, addr_hit;
	logic [31:0] rd_word;
	logic [3:0] nbits;
	logic [8:0] dmask;
	logic tx_tick, tx_load, tx_done, tx_buffer_empty_flag;
	logic rx_sample, rx_start, rx_frame_done, rx_pop, rx_space, rx_push;
	logic rx_complete_flag, rx_ninth_bit, frame_error_flag, overrun_flag, parity_error_flag;
	utrd_rx_entry_t rx_head, rx_new, rx_push_entry;

	// Pin inputs pass two flip-flops; the data pin idles high.
	utrd_sync #(
		.WIDTH(2),
		.RESET_VAL(`UTRD_SYNC_RESET)
	) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.async_in({sync_transfer_clock_pin, serial_in_pin}),
		.sync_out(pins_s)
	);

	// Oversampling tick for asynchronous mode.
	utrd_baud #(
		.DIV_W(DIV_W)
	) u_baud (
		.ref_clk(ref_clk),
		.rst(rst),
		.divisor(baud_div_r),
		.tick(os_tick)
	);

	// Edges of the external transfer clock.
	assign xck_s = pins_s[1];
	assign rxd_s = pins_s[0];
	assign xck_rise = xck_s & ~xck_prev_r;
	assign xck_fall = ~xck_s & xck_prev_r;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			xck_prev_r <= 1'b0;
		else
			xck_prev_r <= xck_s;
	end

	// Frame width and data mask from the size field.
	always_comb
	begin
		if (cfg_r.char_size == `UTRD_CS_NINE)
			nbits = `UTRD_NBITS_NINE;
		else if (cfg_r.char_size[2])
			nbits = `UTRD_NBITS_EIGHT;
		else
			nbits = `UTRD_NBITS_MIN + {2'h0, cfg_r.char_size[1:0]};
		dmask = ~(9'h1ff << nbits);
	end

	// APB: pready rises in the second access cycle; that edge commits.
	assign apb_setup = psel & penable & ~pready_r;
	assign apb_wr = psel & penable & pready_r & pwrite;
	assign apb_rd = psel & penable & pready_r & ~pwrite;

	// Flags seen by software: receive flags from the FIFO head, buffer-empty from the transmit buffer.
	assign rx_head = rx_fifo_r[rx_rd_r];
	assign rx_complete_flag = (rx_count_r != 2'h0);
	assign rx_ninth_bit = rx_complete_flag & rx_head.ninth;
	assign frame_error_flag = rx_complete_flag & rx_head.fe;
	assign overrun_flag = rx_complete_flag & rx_head.dor;
	assign parity_error_flag = rx_complete_flag & rx_head.pe;
	assign tx_buffer_empty_flag = ~tx_buf_full_r;

	// Read multiplexer and address decode.
	always_comb
	begin
		rd_word = 32'h0;
		addr_hit = 1'b1;
		case (paddr)
			`UTRD_OFF_DATA:
				rd_word[7:0] = rx_complete_flag ? rx_head.data : 8'h00;
			`UTRD_OFF_STATUS:
			begin
				rd_word[`UTRD_ST_RXC] = rx_complete_flag;
				rd_word[`UTRD_ST_TXC] = tx_complete_flag;
				rd_word[`UTRD_ST_BE] = tx_buffer_empty_flag;
				rd_word[`UTRD_ST_FE] = frame_error_flag;
				rd_word[`UTRD_ST_DOR] = overrun_flag;
				rd_word[`UTRD_ST_PE] = parity_error_flag;
			end
			`UTRD_OFF_CTRL:
			begin
				rd_word[`UTRD_CT_TXCIE] = tx_complete_irq_enable;
				rd_word[`UTRD_CT_BEIE] = tx_buffer_empty_irq_enable;
				rd_word[`UTRD_CT_RXEN] = receiver_enable;
				rd_word[`UTRD_CT_TRANSMITTER_ENABLE] = transmitter_enable;
				rd_word[`UTRD_CT_CS2] = cfg_r.char_size[2];
				rd_word[`UTRD_CT_RX9] = rx_ninth_bit;
				rd_word[`UTRD_CT_TX9] = tx_ninth_bit;
			end
			`UTRD_OFF_CFG:
			begin
				rd_word[`UTRD_CF_CS_HI:`UTRD_CF_CS_LO] = cfg_r.char_size[1:0];
				rd_word[`UTRD_CF_STOP2] = cfg_r.two_stop;
				rd_word[`UTRD_CF_PAR_HI:`UTRD_CF_PAR_LO] = cfg_r.parity_mode;
				rd_word[`UTRD_CF_SYNC] = cfg_r.sync_mode;
			end
			`UTRD_OFF_BAUD:
				rd_word[DIV_W-1:0] = baud_div_r;
			default:
				addr_hit = 1'b0;
		endcase
	end

	// Bus answer registers.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r <= apb_setup;
			prdata_r <= (apb_setup & ~pwrite) ? rd_word : 32'h0;
			pslverr_r <= apb_setup & ~addr_hit;
		end
	end

	// Control and configuration registers.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			tx_complete_irq_enable <= 1'b0;
			tx_buffer_empty_irq_enable <= 1'b0;
			receiver_enable <= 1'b0;
			transmitter_enable <= 1'b0;
			tx_ninth_bit <= 1'b0;
			cfg_r <= '{sync_mode: 1'b0, parity_mode: 2'h0, two_stop: 1'b0, char_size: `UTRD_CS_RESET};
			baud_div_r <= DIV_W'(`UTRD_BAUD_RESET);
		end
		else if (apb_wr && paddr == `UTRD_OFF_CTRL)
		begin
			tx_complete_irq_enable <= pwdata[`UTRD_CT_TXCIE];
			tx_buffer_empty_irq_enable <= pwdata[`UTRD_CT_BEIE];
			receiver_enable <= pwdata[`UTRD_CT_RXEN];
			transmitter_enable <= pwdata[`UTRD_CT_TRANSMITTER_ENABLE];
			cfg_r.char_size[2] <= pwdata[`UTRD_CT_CS2];
			tx_ninth_bit <= pwdata[`UTRD_CT_TX9];
		end
		else if (apb_wr && paddr == `UTRD_OFF_CFG)
		begin
			cfg_r.char_size[1:0] <= pwdata[`UTRD_CF_CS_HI:`UTRD_CF_CS_LO];
			cfg_r.two_stop <= pwdata[`UTRD_CF_STOP2];
			cfg_r.parity_mode <= pwdata[`UTRD_CF_PAR_HI:`UTRD_CF_PAR_LO];
			cfg_r.sync_mode <= pwdata[`UTRD_CF_SYNC];
		end
		else if (apb_wr && paddr == `UTRD_OFF_BAUD)
			baud_div_r <= pwdata[DIV_W-1:0];
	end

	// Transmit bit clock: falling transfer clock or sixteen oversample ticks.
	assign tx_tick = cfg_r.sync_mode ? xck_fall : (os_tick && tx_os_r == `UTRD_OS_LAST);

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			tx_os_r <= 4'h0;
		else if (os_tick)
			tx_os_r <= tx_os_r + 4'h1;
	end

	// Load when idle or straight after the last stop bit.
	assign tx_load = tx_tick & tx_buf_full_r & tx_active_r & ((tx_state_r == UTRD_IDLE) |
		(tx_state_r == UTRD_STOP & ~tx_stop2_r));
	assign tx_done = tx_tick & (tx_state_r == UTRD_STOP) & ~tx_stop2_r & ~tx_load;

	// Transmit buffer; a new write wins over a load in the same cycle.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			tx_buf_r <= 9'h0;
			tx_buf_full_r <= 1'b0;
		end
		else if (apb_wr && paddr == `UTRD_OFF_DATA)
		begin
			tx_buf_r <= {tx_ninth_bit, pwdata[7:0]};
			tx_buf_full_r <= 1'b1;
		end
		else if (tx_load)
			tx_buf_full_r <= 1'b0;
	end

	// Transmit-complete flag: set wins over service and write-one clear.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			tx_complete_flag <= 1'b0;
		else if (tx_done)
			tx_complete_flag <= 1'b1;
		else if (tx_complete_irq_ack || (apb_wr && paddr == `UTRD_OFF_STATUS && pwdata[`UTRD_ST_TXC]))
			tx_complete_flag <= 1'b0;
	end

	// The transmitter stays on until nothing is left to send.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			tx_active_r <= 1'b0;
		else if (transmitter_enable)
			tx_active_r <= 1'b1;
		else if (~tx_buf_full_r && tx_state_r == UTRD_IDLE)
			tx_active_r <= 1'b0;
	end

	// Transmit shifter; the state names the bit on the line.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			tx_state_r <= UTRD_IDLE;
			tx_shreg_r <= 9'h0;
			tx_bit_r <= 4'h0;
			tx_stop2_r <= 1'b0;
			serial_out_r <= 1'b1;
		end
		else if (tx_load)
		begin
			tx_shreg_r <= tx_buf_r & dmask;
			tx_state_r <= UTRD_START;
			serial_out_r <= 1'b0;
		end
		else if (tx_tick)
		begin
			unique case (tx_state_r)
				UTRD_IDLE:
					serial_out_r <= 1'b1;
				UTRD_START:
				begin
					tx_bit_r <= 4'h0;
					serial_out_r <= tx_shreg_r[0];
					tx_state_r <= UTRD_DATA;
				end
				UTRD_DATA:
				begin
					if (tx_bit_r != nbits - 4'h1)
					begin
						tx_bit_r <= tx_bit_r + 4'h1;
						serial_out_r <= tx_shreg_r[tx_bit_r + 4'h1];
					end
					else if (cfg_r.parity_mode[1])
					begin
						serial_out_r <= (^tx_shreg_r) ^ cfg_r.parity_mode[0];
						tx_state_r <= UTRD_PAR;
					end
					else
					begin
						serial_out_r <= 1'b1;
						tx_stop2_r <= cfg_r.two_stop;
						tx_state_r <= UTRD_STOP;
					end
				end
				UTRD_PAR:
				begin
					serial_out_r <= 1'b1;
					tx_stop2_r <= cfg_r.two_stop;
					tx_state_r <= UTRD_STOP;
				end
				UTRD_STOP:
				begin
					if (tx_stop2_r)
						tx_stop2_r <= 1'b0;
					else
						tx_state_r <= UTRD_IDLE;
				end
				default:
					tx_state_r <= UTRD_IDLE;
			endcase
		end
	end

	// Receive bit clock: rising transfer clock or mid-bit oversample tick.
	assign rx_sample = cfg_r.sync_mode ? xck_rise : (os_tick && rx_os_r == `UTRD_OS_LAST);
	assign rx_start = receiver_enable & (rx_state_r == UTRD_IDLE) & ~rxd_s & (cfg_r.sync_mode ? xck_rise : os_tick);
	assign rx_frame_done = receiver_enable & rx_sample & (rx_state_r == UTRD_STOP);
	assign rx_pop = apb_rd & (paddr == `UTRD_OFF_DATA) & rx_complete_flag;
	assign rx_space = (rx_count_r != `UTRD_FIFO_DEPTH) | rx_pop;
	assign rx_push = rx_space & (rx_hold_v_r | rx_frame_done);

	// Entry built at the first stop bit.
	always_comb
	begin
		rx_new.ninth = rx_shreg_r[8];
		rx_new.data = rx_shreg_r[7:0];
		rx_new.fe = ~rxd_s;
		rx_new.dor = dor_pend_r;
		rx_new.pe = cfg_r.parity_mode[1] & (rx_par_r != ((^(rx_shreg_r & dmask)) ^ cfg_r.parity_mode[0]));
		rx_push_entry = rx_hold_v_r ? rx_hold_r : rx_new;
		rx_push_entry.dor = dor_pend_r;
	end

	// Receive shifter.
	always_ff @(posedge ref_clk)
	begin
		if (rst || !receiver_enable)
		begin
			rx_state_r <= UTRD_IDLE;
			rx_shreg_r <= 9'h0;
			rx_bit_r <= 4'h0;
			rx_os_r <= 4'h0;
			rx_par_r <= 1'b0;
		end
		else if (rx_start)
		begin
			rx_os_r <= 4'h0;
			rx_shreg_r <= 9'h0;
			rx_bit_r <= 4'h0;
			rx_state_r <= cfg_r.sync_mode ? UTRD_DATA : UTRD_START;
		end
		else
		begin
			if (os_tick)
				rx_os_r <= rx_os_r + 4'h1;
			unique case (rx_state_r)
				UTRD_IDLE:
					rx_bit_r <= 4'h0;
				UTRD_START:
				begin
					if (os_tick && rx_os_r == `UTRD_OS_MID)
					begin
						rx_os_r <= 4'h0;
						rx_state_r <= rxd_s ? UTRD_IDLE : UTRD_DATA;
					end
				end
				UTRD_DATA:
				begin
					if (rx_sample)
					begin
						rx_shreg_r[rx_bit_r] <= rxd_s;
						if (rx_bit_r != nbits - 4'h1)
							rx_bit_r <= rx_bit_r + 4'h1;
						else
							rx_state_r <= cfg_r.parity_mode[1] ? UTRD_PAR : UTRD_STOP;
					end
				end
				UTRD_PAR:
				begin
					if (rx_sample)
					begin
						rx_par_r <= rxd_s;
						rx_state_r <= UTRD_STOP;
					end
				end
				UTRD_STOP:
				begin
					if (rx_sample)
						rx_state_r <= UTRD_IDLE;
				end
				default:
					rx_state_r <= UTRD_IDLE;
			endcase
		end
	end

	// Waiting frame, overrun marker and the two-entry receive FIFO.
	always_ff @(posedge ref_clk)
	begin
		if (rst || !receiver_enable)
		begin
			rx_hold_r <= '0;
			rx_hold_v_r <= 1'b0;
			dor_pend_r <= 1'b0;
			rx_rd_r <= 1'b0;
			rx_wr_r <= 1'b0;
			rx_count_r <= 2'h0;
		end
		else
		begin
			if (rx_frame_done && (rx_hold_v_r || !rx_space))
			begin
				rx_hold_r <= rx_new;
				rx_hold_v_r <= 1'b1;
			end
			else if (rx_push && rx_hold_v_r)
				rx_hold_v_r <= 1'b0;
			if (rx_start && rx_hold_v_r && !rx_space)
				dor_pend_r <= 1'b1;
			else if (rx_push)
				dor_pend_r <= 1'b0;
			if (rx_push)
			begin
				rx_fifo_r[rx_wr_r] <= rx_push_entry;
				rx_wr_r <= ~rx_wr_r;
			end
			if (rx_pop)
				rx_rd_r <= ~rx_rd_r;
			rx_count_r <= rx_count_r + {1'b0, rx_push} - {1'b0, rx_pop};
		end
	end

	// Interrupt requests, gated by the global enable.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			irq_be_r <= 1'b0;
			irq_tc_r <= 1'b0;
		end
		else
		begin
			irq_be_r <= tx_buffer_empty_flag & tx_buffer_empty_irq_enable & global_irq_enable;
			irq_tc_r <= (tx_complete_flag | tx_done) & tx_complete_irq_enable & global_irq_enable &
				~tx_complete_irq_ack;
		end
	end

	// Outputs straight from flip-flops.
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq_buffer_empty = irq_be_r;
	assign irq_tx_complete = irq_tc_r;
	assign serial_out_pin = serial_out_r;
	assign serial_out_oe = tx_active_r;
	assign serial_in_override = receiver_enable;
endmodule : utrd_top

// ==== utrd_checker.sv ====
`timescale 1ns/100ps
`include "utrd_map.svh"
module utrd_checker
	import utrd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic global_irq_enable,
	input wire logic irq_buffer_empty,
	input wire logic irq_tx_complete,
	input wire logic serial_out_pin,
	input wire logic serial_out_oe,
	input wire logic serial_in_override
);
	// Every check runs on the system clock and rests during reset.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// A completed control write, then the state of its receiver enable bit.
	sequence s_ctrl_wr;
		psel && penable && pready && pwrite && paddr == `UTRD_OFF_CTRL;
	endsequence
	sequence s_rx_on;
		s_ctrl_wr ##0 pwdata[`UTRD_CT_RXEN];
	endsequence
	sequence s_rx_off;
		s_ctrl_wr ##0 !pwdata[`UTRD_CT_RXEN];
	endsequence
	// Bus answer timing, address decode and pin and interrupt relations.
	property p_rdy_pulse; pready |=> !pready; endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than a cycle");
	property p_rdy_access; pready |-> psel && penable && $past(psel); endproperty
	a_rdy_access: assert property (p_rdy_access) else $error("pready outside access");
	property p_unmapped; pready && paddr > `UTRD_OFF_BAUD |-> pslverr; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_rx_on; s_rx_on |=> serial_in_override; endproperty
	a_rx_on: assert property (p_rx_on) else $error("input pin not taken");
	property p_rx_off; s_rx_off |=> !serial_in_override; endproperty
	a_rx_off: assert property (p_rx_off) else $error("input pin not released");
	property p_idle_high; !serial_out_oe |-> serial_out_pin; endproperty
	a_idle_high: assert property (p_idle_high) else $error("released line not high");
	property p_start_len; $fell(serial_out_pin) |-> !serial_out_pin [*8]; endproperty
	a_start_len: assert property (p_start_len) else $error("low bit too short");
	property p_oe_drop; $fell(serial_out_oe) |-> serial_out_pin && $past(serial_out_pin); endproperty
	a_oe_drop: assert property (p_oe_drop) else $error("pin released mid frame");
	property p_be_mask; !global_irq_enable |=> !irq_buffer_empty; endproperty
	a_be_mask: assert property (p_be_mask) else $error("empty irq not masked");
	property p_tc_mask; !global_irq_enable |=> !irq_tx_complete; endproperty
	a_tc_mask: assert property (p_tc_mask) else $error("complete irq not masked");
	property p_rd_short; pready && !pwrite && paddr == `UTRD_OFF_DATA |-> prdata[31:8] == '0; endproperty
	a_rd_short: assert property (p_rd_short) else $error("data upper bits set");
endmodule : utrd_checker

// ==== utrd_remote.sv ====
`timescale 1ns/100ps
module utrd_remote
#(
	parameter int BIT_CLKS = 16
)
(
	input wire logic ref_clk,
	input wire logic serial_out_pin,
	output logic serial_in_pin
);
	// The line rests high while no frame is sent.
	initial serial_in_pin = 1'b1;
	// Sends start, data LSB first, optional parity and one stop, then returns the line high.
	task automatic send(input logic [8:0] d, input int nb, input logic pe, input logic p, input logic sp);
		for (int i = 0; i < nb + 2 + pe; i++)
		begin
			@(posedge ref_clk);
			serial_in_pin <= (i == 0) ? 1'b0 : (i <= nb) ? d[i - 1] : (pe && i == nb + 1) ? p : sp;
			repeat (BIT_CLKS - 1) @(posedge ref_clk);
		end
		@(posedge ref_clk);
		serial_in_pin <= 1'b1;
	endtask : send
	// Captures n bits of an outgoing frame at mid-bit; it returns in the middle of the last bit.
	task automatic grab(input int n, output logic [31:0] f);
		f = '0;
		do
			@(posedge ref_clk);
		while (serial_out_pin !== 1'b0);
		repeat (BIT_CLKS / 2 - 1) @(posedge ref_clk);
		f[0] = serial_out_pin;
		for (int i = 1; i < n; i++)
		begin
			repeat (BIT_CLKS) @(posedge ref_clk);
			f[i] = serial_out_pin;
		end
	endtask : grab
endmodule : utrd_remote

// ==== usart_tx_rx_datapath_tb_top.sv ====
`timescale 1ns/100ps
`include "utrd_map.svh"
module usart_tx_rx_datapath_tb_top
	import utrd_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic global_irq_enable = 1'b0;
	logic tx_complete_irq_ack = 1'b0;
	logic sync_transfer_clock_pin = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd, f1, f2;
	logic pready, pslverr, irq_buffer_empty, irq_tx_complete, err;
	logic serial_out_pin, serial_out_oe, serial_in_pin, serial_in_override;
	int bad_count = 0;
	int num_checks = 0;
	int cyc = 0;
	// Transmit cases: frame config, character and width, covering size codes 0 to 3 and 7, so every width from 5 to 9 bits.
	localparam logic [7:0] TCFG [5] = '{8'h03, 8'h22, 8'h30, 8'h03, 8'h01};
	localparam logic [8:0] TDAT [5] = '{9'h0a5, 9'h05b, 9'h013, 9'h1c6, 9'h02d};
	localparam int TNB [5] = '{8, 7, 5, 9, 6};
	utrd_top #(.DIV_W(16)) utrd_top_i (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.global_irq_enable(global_irq_enable), .tx_complete_irq_ack(tx_complete_irq_ack),
		.irq_buffer_empty(irq_buffer_empty), .irq_tx_complete(irq_tx_complete), .serial_out_pin(serial_out_pin),
		.serial_out_oe(serial_out_oe), .serial_in_pin(serial_in_pin), .serial_in_override(serial_in_override),
		.sync_transfer_clock_pin(sync_transfer_clock_pin));
	utrd_remote utrd_remote_i (.ref_clk(ref_clk), .serial_out_pin(serial_out_pin), .serial_in_pin(serial_in_pin));
	// Free-running system clock.
	always #5 ref_clk = ~ref_clk;
	// Cuts a hung run short.
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count++;
			results();
		end
	end
	// Counts a comparison and reports a mismatch.
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			$display("FAIL %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask : chk
	// One APB transfer; the request holds until pready is seen at a rising edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Reads a register and compares the masked value.
	task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
		apb(1'b0, a, '0);
		chk(nm, e, rd & m);
	endtask : rdc
	// Expected line bits of a frame with one stop, start bit in bit 0.
	function automatic logic [31:0] frm(input logic [8:0] d, input int nb, input logic pe, input logic odd);
		logic [31:0] f;
		logic p;
		f = '0;
		p = odd;
		for (int i = 0; i < nb; i++)
		begin
			f[i + 1] = d[i];
			p = p ^ d[i];
		end
		if (pe)
			f[nb + 1] = p;
		f[nb + 1 + pe] = 1'b1;
		return f;
	endfunction : frm
	// Prints the counts and the verdict, then ends the run.
	task results;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results
	// Main sequence: reset values, transmit cases, deferred disable, then reception.
	initial
	begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		global_irq_enable <= 1'b1;
		rdc(`UTRD_OFF_CTRL, '1, 32'h0, "ctrl reset");
		rdc(`UTRD_OFF_CFG, '1, 32'h3, "cfg reset");
		rdc(`UTRD_OFF_BAUD, '1, 32'h40, "baud reset");
		rdc(`UTRD_OFF_STATUS, 32'hff, 32'h20, "status reset");
		apb(1'b0, 12'h014, '0);
		chk("unmapped refused", 1, err);
		apb(1'b1, `UTRD_OFF_BAUD, 32'h0);
		for (int k = 0; k < 5; k++)
		begin
			apb(1'b1, `UTRD_OFF_CFG, 32'(TCFG[k]));
			apb(1'b1, `UTRD_OFF_CTRL, (TNB[k] == 9) ? 32'h6d : 32'h68);
			fork
				utrd_remote_i.grab(TNB[k] + 2 + TCFG[k][5], f1);
				apb(1'b1, `UTRD_OFF_DATA, 32'(TDAT[k]));
			join
			chk("tx frame", frm(TDAT[k], TNB[k], TCFG[k][5], TCFG[k][4]), f1);
			repeat (16) @(posedge ref_clk);
		end
		chk("complete irq", 1, irq_tx_complete);
		chk("empty irq", 1, irq_buffer_empty);
		global_irq_enable <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk("empty irq masked", 0, irq_buffer_empty);
		global_irq_enable <= 1'b1;
		rdc(`UTRD_OFF_STATUS, 32'h60, 32'h60, "tx idle status");
		apb(1'b1, `UTRD_OFF_STATUS, 32'h40);
		rdc(`UTRD_OFF_STATUS, 32'h40, 32'h0, "complete cleared");
		apb(1'b1, `UTRD_OFF_CFG, 32'h03);
		fork
			begin
				utrd_remote_i.grab(10, f1);
				utrd_remote_i.grab(10, f2);
			end
			begin
				apb(1'b1, `UTRD_OFF_DATA, 32'h3c);
				// Software waits for the buffer to drain before the next character.
				do
					apb(1'b0, `UTRD_OFF_STATUS, '0);
				while (rd[`UTRD_ST_BE] !== 1'b1);
				apb(1'b1, `UTRD_OFF_DATA, 32'hc3);
				rdc(`UTRD_OFF_STATUS, 32'h20, 32'h0, "buffer full");
				apb(1'b1, `UTRD_OFF_CTRL, 32'h60);
				chk("pin held", 1, serial_out_oe);
			end
		join
		chk("first frame", frm(9'h3c, 8, 0, 0), f1);
		chk("second frame", frm(9'hc3, 8, 0, 0), f2);
		repeat (24) @(posedge ref_clk);
		chk("pin released", 0, serial_out_oe);
		tx_complete_irq_ack <= 1'b1;
		@(posedge ref_clk);
		tx_complete_irq_ack <= 1'b0;
		rdc(`UTRD_OFF_STATUS, 32'h40, 32'h0, "complete serviced");
		apb(1'b1, `UTRD_OFF_CTRL, 32'h10);
		@(posedge ref_clk);
		chk("input taken", 1, serial_in_override);
		apb(1'b1, `UTRD_OFF_CFG, 32'h2a);
		utrd_remote_i.send(9'h07f, 7, 1'b1, 1'b0, 1'b1);
		utrd_remote_i.send(9'h055, 7, 1'b1, 1'b0, 1'b1);
		repeat (20) @(posedge ref_clk);
		rdc(`UTRD_OFF_STATUS, 32'h9c, 32'h84, "parity error head");
		rdc(`UTRD_OFF_DATA, '1, 32'h7f, "short data");
		rdc(`UTRD_OFF_STATUS, 32'h9c, 32'h80, "next entry flags");
		rdc(`UTRD_OFF_DATA, '1, 32'h55, "next entry data");
		rdc(`UTRD_OFF_STATUS, 32'h80, 32'h0, "fifo empty");
		apb(1'b1, `UTRD_OFF_CTRL, 32'h14);
		apb(1'b1, `UTRD_OFF_CFG, 32'h03);
		utrd_remote_i.send(9'h1a5, 9, 1'b0, 1'b0, 1'b0);
		repeat (20) @(posedge ref_clk);
		rdc(`UTRD_OFF_STATUS, 32'h9c, 32'h90, "frame error");
		rdc(`UTRD_OFF_CTRL, 32'h2, 32'h2, "ninth bit");
		rdc(`UTRD_OFF_DATA, '1, 32'ha5, "nine bit low");
		// Synchronous reception: the bench rises the transfer clock in mid-bit.
		apb(1'b1, `UTRD_OFF_CTRL, 32'h10);
		apb(1'b1, `UTRD_OFF_CFG, 32'h43);
		fork
			utrd_remote_i.send(9'h0c9, 8, 1'b0, 1'b0, 1'b1);
			begin
				repeat (8) @(posedge ref_clk);
				repeat (10)
				begin
					sync_transfer_clock_pin <= 1'b1;
					repeat (8) @(posedge ref_clk);
					sync_transfer_clock_pin <= 1'b0;
					repeat (8) @(posedge ref_clk);
				end
			end
		join
		repeat (4) @(posedge ref_clk);
		rdc(`UTRD_OFF_DATA, '1, 32'hc9, "sync data");
		apb(1'b1, `UTRD_OFF_CTRL, 32'h0);
		@(posedge ref_clk);
		chk("input released", 0, serial_in_override);
		results();
	end
endmodule : usart_tx_rx_datapath_tb_top
bind utrd_top utrd_checker utrd_checker_i (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.global_irq_enable(global_irq_enable), .irq_buffer_empty(irq_buffer_empty), .irq_tx_complete(irq_tx_complete),
	.serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe), .serial_in_override(serial_in_override));
